// ===== core/adc_timing_defs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * converter sequencer. assumes a 40 MHz bus clock and byte addresses.
 */
`ifndef ADC_TIMING_DEFS_SVH
`define ADC_TIMING_DEFS_SVH

// ============================================================
// register offsets
`define OFS_CONFIG          8'h00
`define OFS_COMMAND         8'h04
`define OFS_STATUS          8'h08
`define OFS_MASK            8'h0c
`define OFS_RESULT          8'h10
`define OFS_COMPARE         8'h14

// ============================================================
// field positions
`define CMD_START_BIT       0
`define CMD_ABORT_BIT       1
`define STAT_COMPLETE_BIT   0
`define STAT_MISS_BIT       1
`define STAT_ACTIVE_BIT     8
`define CONFIG_WIDTH        18
`define CONFIG_RESET        18'h00000
`define MASK_RESET          2'h0

// ============================================================
// timing counts
`define CLK_PERIOD_NS       25
`define STARTUP_TIME_NS     5000
`define STARTUP_CYCLES      ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIRST_BUS_CYCLES    5
`define FIRST_LONG_CYCLES   3
`define FIRST_SHORT_CYCLES  5
`define HIGH_SPEED_CYCLES   4
`define SHORT_SAMPLE_CYCLES 4
`define BCT_8_SE            17
`define BCT_9_DIFF          27
`define BCT_10_12_SE        20
`define BCT_11_13_DIFF      30
`define BCT_16_SE           25
`define BCT_16_DIFF         34
`define LST_SEL0            20
`define LST_SEL1            12
`define LST_SEL2            6
`define LST_SEL3            2
`define ASYNC_DIVISOR       4

`endif

// ===== core/adc_timing_pkg.sv
/*
 * types shared by the converter sequencer and its clock divider.
 * assumes adc_timing_defs.svh is on the include path.
 */
package adc_timing_pkg;

    // ============================================================
    // configuration word
    typedef struct packed {
        logic       complete_interrupt_enable;
        logic       compare_enable;
        logic [1:0] resolution_mode;
        logic       differential_select;
        logic       continuous_enable;
        logic [1:0] average_count_select;
        logic       average_enable;
        logic       async_clock_output_enable;
        logic       high_speed_config;
        logic [1:0] long_sample_select;
        logic       long_sample_enable;
        logic [1:0] clock_divide_select;
        logic [1:0] input_clock_select;
    } config_type;

    // ============================================================
    // sequencer phases
    typedef enum logic [5:0] {
        PH_IDLE    = 6'h01,
        PH_STARTUP = 6'h02,
        PH_FIRST   = 6'h04,
        PH_SAMPLE  = 6'h08,
        PH_CONVERT = 6'h10,
        PH_POST    = 6'h20
    } phase_type;

    typedef struct packed {
        config_type  cfg;
        logic [15:0] compare_value;
        logic [1:0]  mask;
        logic [1:0]  status;
        logic [15:0] result;
        logic [20:0] acc;
        logic [5:0]  conv_count;
        logic [8:0]  count;
        phase_type   phase;
        logic [31:0] rdata;
        logic        irq;
        logic        sampling;
        logic        approximating;
    } seq_state_type;

    typedef struct packed {
        logic [2:0] sync;
        logic       ext_level;
        logic [7:0] async_count;
        logic       bus_half;
        logic [7:0] div_count;
        logic       tick;
    } div_state_type;

endpackage : adc_timing_pkg

// ===== core/conv_clock_divider.sv
/*
 * conversion clock enable: picks a source and divides it by 1, 2, 4 or 8.
 * assumes one bus clock; the alternate clock pin is asynchronous.
 */
`include "adc_timing_defs.svh"

module conv_clock_divider
    import adc_timing_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] input_clock_select,
    input  wire logic [1:0] clock_divide_select,
    input  wire logic       async_run,
    input  wire logic       alt_clock_pin,
    output logic            tick
);

    div_state_type cur;
    div_state_type next;
    logic          src;
    logic          ext_rise;
    logic [7:0]    div_last;

    // ============================================================
    // source selection and divide
    always_comb begin
        next = cur;
        next.sync = {cur.sync[1:0], alt_clock_pin};
        ext_rise = 1'b0;
        if (cur.sync[2] == cur.sync[1]) begin
            next.ext_level = cur.sync[2];
            ext_rise = cur.sync[2] & ~cur.ext_level;
        end
        next.bus_half = ~cur.bus_half;
        next.async_count = '0;
        if (async_run && (cur.async_count != 8'(`ASYNC_DIVISOR - 1))) begin
            next.async_count = cur.async_count + 8'h01;
        end
        unique case (input_clock_select)
            2'h0: src = 1'b1;
            2'h1: src = cur.bus_half;
            2'h2: src = ext_rise;
            2'h3: src = async_run && (cur.async_count == 8'(`ASYNC_DIVISOR - 1));
        endcase
        div_last = (8'h01 << clock_divide_select) - 8'h01;
        next.tick = 1'b0;
        if (src) begin
            if (cur.div_count >= div_last) begin
                next.div_count = '0;
                next.tick = 1'b1;
            end else begin
                next.div_count = cur.div_count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    assign tick = cur.tick;

endmodule : conv_clock_divider

// ===== core/adc_conversion_timing_averager.sv
/*
 * sequencing, timing and hardware averaging of a successive-approximation
 * converter with a plain register port.
 * assumes the analogue front end presents a settled approximation value
 * on approx_value in the cycle after approximating falls, on the same clock.
 */
// The plain strobed port and the placing of the registers were decided locally.
// Summary of operation
// - high speed configuration adds four conversion-clock cycles to every conversion
// - on start sample the input, then isolate it and approximate
// - finished approximation moves the value into the result register
// - latency is first adder plus factor times base, long-sample and high-speed adders; each conversion also takes one bus cycle to post
// - first adder is 3 or 5 conversion cycles plus 5 bus cycles
// - async source with output disabled adds a 5 us startup delay
// - average factor is 1, or 4, 8, 16, 32 by selector
// - base time is 17, 27, 20, 30, 25 or 34 cycles by mode
// - long-sample adder is 0, or 20, 12, 6, 2 cycles by selector
// - conversion clock is the selected source divided by the selected ratio
// - active flag stays set throughout an averaging sequence
// - each result accumulates; single results of a set never flag completion
// - after the set, passing results post and flag completion, interrupt if enabled
// - averaging keeps running in wait and stop3; interrupt requests wake
// - continuous averaging restarts a fresh set right after the last conversion
// - compare looks at the averaged value, not single results
// - failed compare leaves results untouched and no completion flag
`include "adc_timing_defs.svh"

module adc_conversion_timing_averager
    import adc_timing_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             irq,
    output logic             wake_request,
    output logic             sampling,
    output logic             approximating,
    output logic             active_flag,
    input  wire logic [15:0] approx_value,
    input  wire logic        alt_clock_pin
);

    seq_state_type cur;
    seq_state_type next;
    logic          ck_tick;
    logic [8:0]    startup_len;
    logic [8:0]    first_len;
    logic [8:0]    sample_len;
    logic [8:0]    convert_len;
    logic [8:0]    base_conversion_time;
    logic [8:0]    lst;
    logic [8:0]    hsc;
    logic [2:0]    avg_shift;
    logic [5:0]    avg_num;
    logic [20:0]   sum;
    logic [15:0]   avg;
    logic          cmp_pass;
    logic [1:0]    events;
    logic          last_of_set;

    // ============================================================
    // conversion clock
    conv_clock_divider u_div (
        .clk                 (clk),
        .rst_n               (rst_n),
        .input_clock_select  (cur.cfg.input_clock_select),
        .clock_divide_select (cur.cfg.clock_divide_select),
        .async_run           (cur.cfg.async_clock_output_enable || (cur.phase != PH_IDLE)),
        .alt_clock_pin       (alt_clock_pin),
        .tick                (ck_tick)
    );

    // ============================================================
    // phase lengths
    always_comb begin
        hsc = cur.cfg.high_speed_config ? 9'(`HIGH_SPEED_CYCLES) : 9'h000;
        unique case (cur.cfg.long_sample_select)
            2'h0: lst = 9'(`LST_SEL0);
            2'h1: lst = 9'(`LST_SEL1);
            2'h2: lst = 9'(`LST_SEL2);
            2'h3: lst = 9'(`LST_SEL3);
        endcase
        if (!cur.cfg.long_sample_enable) begin
            lst = 9'h000;
        end
        unique case ({cur.cfg.resolution_mode, cur.cfg.differential_select})
            3'h0: base_conversion_time = 9'(`BCT_8_SE);
            3'h1: base_conversion_time = 9'(`BCT_9_DIFF);
            3'h2: base_conversion_time = 9'(`BCT_10_12_SE);
            3'h3: base_conversion_time = 9'(`BCT_11_13_DIFF);
            3'h4: base_conversion_time = 9'(`BCT_10_12_SE);
            3'h5: base_conversion_time = 9'(`BCT_11_13_DIFF);
            3'h6: base_conversion_time = 9'(`BCT_16_SE);
            3'h7: base_conversion_time = 9'(`BCT_16_DIFF);
        endcase
        startup_len = 9'(`FIRST_BUS_CYCLES);
        if ((cur.cfg.input_clock_select == 2'h3) && !cur.cfg.async_clock_output_enable) begin
            startup_len = 9'(`FIRST_BUS_CYCLES + `STARTUP_CYCLES);
        end
        first_len = cur.cfg.long_sample_enable ? 9'(`FIRST_LONG_CYCLES) : 9'(`FIRST_SHORT_CYCLES);
        sample_len = 9'(`SHORT_SAMPLE_CYCLES) + lst;
        convert_len = base_conversion_time - 9'(`SHORT_SAMPLE_CYCLES) + hsc;
        avg_shift = cur.cfg.average_enable ? (3'h2 + {1'b0, cur.cfg.average_count_select}) : 3'h0;
        avg_num = 6'h01 << avg_shift;
    end

    // ============================================================
    // averaging and compare
    always_comb begin
        sum = cur.acc + {5'h00, approx_value};
        avg = 16'(sum >> avg_shift);
        if (cur.cfg.compare_enable) begin
            cmp_pass = cur.cfg.resolution_mode[0] ? (avg >= cur.compare_value)
                                                  : (avg < cur.compare_value);
        end else begin
            cmp_pass = 1'b1;
        end
        last_of_set = (cur.conv_count + 6'h01) == avg_num;
    end

    // ============================================================
    // sequencer and register port
    always_comb begin
        next = cur;
        next.rdata = '0;
        events = 2'h0;
        unique case (cur.phase)
            PH_IDLE: begin
                next.count = '0;
            end
            PH_STARTUP: begin
                if (cur.count + 9'h001 >= startup_len) begin
                    next.phase = PH_FIRST;
                    next.count = '0;
                end else begin
                    next.count = cur.count + 9'h001;
                end
            end
            PH_FIRST: begin
                if (ck_tick) begin
                    if (cur.count + 9'h001 >= first_len) begin
                        next.phase = PH_SAMPLE;
                        next.count = '0;
                    end else begin
                        next.count = cur.count + 9'h001;
                    end
                end
            end
            PH_SAMPLE: begin
                if (ck_tick) begin
                    if (cur.count + 9'h001 >= sample_len) begin
                        next.phase = PH_CONVERT;
                        next.count = '0;
                    end else begin
                        next.count = cur.count + 9'h001;
                    end
                end
            end
            PH_CONVERT: begin
                if (ck_tick) begin
                    if (cur.count + 9'h001 >= convert_len) begin
                        next.phase = PH_POST;
                        next.count = '0;
                    end else begin
                        next.count = cur.count + 9'h001;
                    end
                end
            end
            PH_POST: begin
                next.phase = PH_SAMPLE;
                next.acc = sum;
                next.conv_count = cur.conv_count + 6'h01;
                if (last_of_set) begin
                    if (cmp_pass) begin
                        next.result = avg;
                        events[`STAT_COMPLETE_BIT] = 1'b1;
                    end else begin
                        events[`STAT_MISS_BIT] = 1'b1;
                    end
                    next.acc = '0;
                    next.conv_count = '0;
                    if (!cur.cfg.continuous_enable) begin
                        next.phase = PH_IDLE;
                    end
                end
            end
            default: begin
                next.phase = PH_IDLE;
            end
        endcase

        if (rd) begin
            unique case (addr)
                `OFS_CONFIG:  next.rdata = 32'(cur.cfg);
                `OFS_STATUS: begin
                    next.rdata[1:0] = cur.status;
                    next.rdata[`STAT_ACTIVE_BIT] = cur.phase != PH_IDLE;
                end
                `OFS_MASK:    next.rdata = {30'h00000000, cur.mask};
                `OFS_RESULT:  next.rdata = {16'h0000, cur.result};
                `OFS_COMPARE: next.rdata = {16'h0000, cur.compare_value};
                default:      next.rdata = '0;
            endcase
        end

        if (wr) begin
            unique case (addr)
                `OFS_CONFIG: begin
                    next.cfg = config_type'(wdata[`CONFIG_WIDTH-1:0]);
                    next.mask[`STAT_COMPLETE_BIT] = wdata[`CONFIG_WIDTH-1];
                    next.phase = PH_IDLE;
                end
                `OFS_COMMAND: begin
                    if (wdata[`CMD_ABORT_BIT]) begin
                        next.phase = PH_IDLE;
                    end else if (wdata[`CMD_START_BIT]) begin
                        next.phase = PH_STARTUP;
                        next.count = '0;
                        next.acc = '0;
                        next.conv_count = '0;
                    end
                end
                `OFS_MASK: begin
                    next.mask = wdata[1:0];
                    next.cfg.complete_interrupt_enable = wdata[`STAT_COMPLETE_BIT];
                end
                `OFS_COMPARE: begin
                    next.compare_value = wdata[15:0];
                    next.phase = PH_IDLE;
                end
                default: begin
                end
            endcase
        end

        // set wins over the clear on read
        next.status = ((rd && (addr == `OFS_STATUS)) ? 2'h0 : cur.status) | events;
        next.irq = |(next.status & next.mask);
        next.sampling = next.phase == PH_SAMPLE;
        next.approximating = next.phase == PH_CONVERT;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.phase <= PH_IDLE;
            cur.cfg <= config_type'(`CONFIG_RESET);
            cur.mask <= `MASK_RESET;
        end else begin
            cur <= next;
        end
    end

    // ============================================================
    // outputs
    logic wake_q;
    logic active_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            wake_q <= next.irq;
            active_q <= next.phase != PH_IDLE;
        end
    end

    assign rdata = cur.rdata;
    assign irq = cur.irq;
    assign wake_request = wake_q;
    assign sampling = cur.sampling;
    assign approximating = cur.approximating;
    assign active_flag = active_q;

endmodule : adc_conversion_timing_averager

// ===== bench/adc_timing_checker_assertions.sv
/* port checks of the converter sequencer.
   assumes one clock, sync active-low reset, defs header on the path. */
`include "adc_timing_defs.svh"
module adc_timing_checker
    import adc_timing_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    input wire logic        wake_request,
    input wire logic        sampling,
    input wire logic        approximating,
    input wire logic        active_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] cfg_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= 18'h00000;
        end else if (wr && addr == `OFS_CONFIG) begin
            cfg_q <= wdata[17:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // assertions
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its slot");
    irq_wake_a: assert property (irq == wake_request)
        else $error("wake request differs from interrupt");
    phase_excl_a: assert property (!(sampling && approximating))
        else $error("sampling while isolated");
    sample_isolate_a: assert property ($fell(sampling) && !$past(wr) |-> approximating)
        else $error("sampling ended without approximation");
    phase_active_a: assert property ((sampling || approximating) |-> active_flag)
        else $error("active flag low during a conversion");
    sample_short_a: assert property (disable iff (!rst_n || wr)
        $rose(sampling) && cfg_q[4:0] == 5'h00 |-> sampling[*4] ##1 !sampling)
        else $error("short sample length wrong");
    irq_sticky_a: assert property ($past(irq) && !$past(rd) && !$past(rd, 2)
        && !$past(wr) && !$past(wr, 2) |-> irq)
        else $error("interrupt dropped without a read");
    approx_next_a: assert property ($fell(approximating) |-> ##[1:40] (sampling || !active_flag))
        else $error("no next conversion after approximation");

    cover property ($rose(irq));
    cover property ($fell(approximating) ##[1:3] sampling);
    cover property ($fell(active_flag));
endmodule : adc_timing_checker

// ===== bench/analog_front_model.sv
/* front-end model: one code per conversion, base plus a count.
   assumes the code is taken in the cycle after approximating. */
module analog_front_model (
    input  wire logic        clk,
    input  wire logic        clear,
    input  wire logic        approximating,
    input  wire logic [15:0] base_code,
    output logic      [15:0] approx_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] step = 16'h0000;
    logic        held = 1'b0;

    always @(posedge clk) begin
        held <= approximating;
        if (clear) begin
            step <= 16'h0000;
        end else if (held && !approximating) begin
            step <= step + 16'h0001;
        end
    end
    // code settled while isolated and in the post cycle, else inverted
    assign approx_value = (approximating || held) ? base_code + step : ~(base_code + step);
endmodule : analog_front_model

// ===== bench/testbench.sv
/* self-checking bench of the converter sequencer.
   assumes the front-end model and checker are compiled first. */
`include "adc_timing_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        clear_model = 1'b1;
    logic        alt_clock_pin = 1'b0;
    logic [15:0] base_code = 16'h0000;
    logic [31:0] rdata;
    logic        irq;
    logic        wake_request;
    logic        sampling;
    logic        approximating;
    logic        active_flag;
    logic [15:0] approx_value;
    int          fail_count = 0;
    int          tests_run = 0;
    int          ref_lat = -1;
    logic [17:0] cases [17] = '{18'h20000, 18'h20080, 18'h22000, 18'h24000, 18'h26000, 18'h28000,
        18'h2a000, 18'h2c000, 18'h2e000, 18'h20010, 18'h20030, 18'h20050, 18'h20070, 18'h20200,
        18'h20600, 18'h20a00, 18'h2ee10};

    always #12.5 clk = ~clk;
    always #61 alt_clock_pin = ~alt_clock_pin;

    adc_conversion_timing_averager uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake_request(wake_request),
        .sampling(sampling), .approximating(approximating), .active_flag(active_flag),
        .approx_value(approx_value), .alt_clock_pin(alt_clock_pin));
    analog_front_model front (.clk(clk), .clear(clear_model), .approximating(approximating),
        .base_code(base_code), .approx_value(approx_value));

    // ============================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic report_and_stop;
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic wait_on(input bit for_irq, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((for_irq ? irq !== 1'b1 : active_flag !== 1'b0) && n < 4000);
        if (n >= 4000) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, n, 1);
            report_and_stop();
        end
    endtask : wait_on

    task automatic start_run(input logic [17:0] c, input logic [15:0] b, input bit w, output int n);
        clear_model <= 1'b1;
        base_code <= b;
        wr_reg(`OFS_CONFIG, {14'h0, c});
        clear_model <= 1'b0;
        wr_reg(`OFS_COMMAND, 32'h1);
        if (!w) repeat (4) @(posedge clk);
        wait_on(w, n);
    endtask : start_run

    function automatic int exp_cycles(input logic [17:0] c);
        int base_conversion_time;
        int lst;
        base_conversion_time = c[13] ? 27 : 17;
        if (c[15:14] == 2'h1 || c[15:14] == 2'h2) base_conversion_time = c[13] ? 30 : 20;
        if (c[15:14] == 2'h3) base_conversion_time = c[13] ? 34 : 25;
        lst = !c[4] ? 0 : c[6:5] == 2'h0 ? 20 : c[6:5] == 2'h1 ? 12 : c[6:5] == 2'h2 ? 6 : 2;
        return 5 + (c[4] ? 3 : 5) + (c[9] ? 4 << c[11:10] : 1) * (base_conversion_time + lst + (c[7] ? 4 : 0) + 1);
    endfunction : exp_cycles

    // ============================================================
    // scenarios
    task automatic reg_test;
        logic [31:0] d;
        logic [7:0]  ofs [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
        foreach (ofs[i]) begin
            rd_reg(ofs[i], d);
            check(d, 32'h0);
        end
        wr_reg(8'h20, 32'hffff_ffff);
        wr_reg(`OFS_CONFIG, 32'h3ffff);
        rd_reg(`OFS_CONFIG, d);
        check(d, 32'h3ffff);
        rd_reg(8'h20, d);
        check(d, 32'h0);
        wr_reg(`OFS_CONFIG, 32'h0);
        $display("done: registers");
    endtask : reg_test

    task automatic run_case(input logic [17:0] c, input logic [15:0] b);
        int          n;
        logic [31:0] d;
        start_run(c, b, 1'b1, n);
        if (ref_lat < 0) begin
            ref_lat = n;
            check(32'(n >= 28 && n <= 31), 32'h1);
        end
        check(32'(n - ref_lat), 32'(exp_cycles(c) - 28));
        rd_reg(`OFS_RESULT, d);
        check(d, 32'(b + 16'(((c[9] ? 4 << c[11:10] : 1) - 1) / 2)));
        rd_reg(`OFS_STATUS, d);
        check(d, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check(32'(irq), 32'h0);
    endtask : run_case

    task automatic async_test;
        int          n1;
        int          n2;
        int          n3;
        logic [31:0] d;
        wr_reg(`OFS_CONFIG, 32'h20103);
        repeat (200) @(posedge clk);
        start_run(18'h20103, 16'h0, 1'b1, n1);
        rd_reg(`OFS_STATUS, d);
        start_run(18'h20003, 16'h0, 1'b1, n2);
        rd_reg(`OFS_STATUS, d);
        check(32'(n1 - ref_lat - 22 * (`ASYNC_DIVISOR - 1) inside {[-4:4]}), 32'h1);
        check(32'(n2 - n1 - `STARTUP_CYCLES inside {[-3:3]}), 32'h1);
        start_run(18'h20005, 16'h0, 1'b1, n3);
        rd_reg(`OFS_STATUS, d);
        check(32'(n3 - ref_lat - 22 * 3 inside {[-4:4]}), 32'h1);
        start_run(18'h20002, 16'h0, 1'b1, n3);
        rd_reg(`OFS_STATUS, d);
        check(32'(n3 - ref_lat inside {[78:89]}), 32'h1);
        $display("done: async source");
    endtask : async_test

    task automatic cont_test;
        int          n;
        logic [31:0] d;
        start_run(18'h21200, 16'h0040, 1'b1, n);
        rd_reg(`OFS_RESULT, d);
        check(d, 32'h41);
        rd_reg(`OFS_STATUS, d);
        check(d, 32'h101);
        repeat (2) @(posedge clk);
        wait_on(1'b1, n);
        check(32'(active_flag), 32'h1);
        rd_reg(`OFS_RESULT, d);
        check(d, 32'h45);
        wr_reg(`OFS_COMMAND, 32'h2);
        wait_on(1'b0, n);
        rd_reg(`OFS_STATUS, d);
        $display("done: continuous");
    endtask : cont_test

    task automatic cmp_test;
        int          n;
        logic [31:0] d;
        wr_reg(`OFS_COMPARE, 32'h0102);
        start_run(18'h14200, 16'h0100, 1'b0, n);
        rd_reg(`OFS_STATUS, d);
        check(d, 32'h2);
        rd_reg(`OFS_RESULT, d);
        check(d, 32'h45);
        wr_reg(`OFS_COMPARE, 32'h0101);
        start_run(18'h14200, 16'h0100, 1'b0, n);
        check(32'(irq), 32'h0);
        rd_reg(`OFS_RESULT, d);
        check(d, 32'h101);
        wr_reg(`OFS_MASK, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check(32'(irq), 32'h1);
        rd_reg(`OFS_STATUS, d);
        check(d, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check(32'(irq), 32'h0);
        $display("done: compare and mask");
    endtask : cmp_test

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        reg_test();
        foreach (cases[i]) begin
            run_case(cases[i], 16'(16'h0100 * i + 16'h0003));
        end
        $display("done: timing table");
        async_test();
        cont_test();
        cmp_test();
        report_and_stop();
    end
endmodule : testbench

bind adc_conversion_timing_averager adc_timing_checker chk (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake_request(wake_request),
    .sampling(sampling), .approximating(approximating), .active_flag(active_flag));
